// ### design/sqsc_sequencer.sv
// sqsc_sequencer: program sequencer control, privilege, counters, call stack pointer,
// interrupt flags and vectoring, with avalon-mm access to the status registers
// assumes the decoder presents one executing instruction per cycle, synchronous inputs
`timescale 1ns/1ps

module sqsc_sequencer
  import sqsc_pkg::*;
#(
  parameter logic [31:0] RESET_ADDR = 32'h00000000
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  output logic [1:0]            avs_response,
  // supervisor access qualifier from the issuing context
  input  wire logic             busSuper,
  // executing instruction from the decoder
  input  wire sqsc_instr_t      instr,
  input  wire logic [31:0]      stackTop,
  // external interrupt lines, active low, and internal event pulses
  input  wire logic [3:0]       extIrqN,
  input  wire logic             malEvent,
  input  wire logic             timEvent,
  input  wire logic             brkEvent,
  output sqsc_seq_t             seqOut,
  output logic                  squashShadow,
  output logic                  bankSel,
  output logic [31:0]           execAddr,
  output logic [31:0]           lastAddr,
  output logic [31:0]           irqExecSave,
  output logic [31:0]           irqFetchSave,
  output logic [31:0]           addrHold,
  output logic                  irqTaken,
  output logic [31:0]           ssrOut
);

  sqsc_state_t   state_reg;
  logic [31:0]   ssr_reg;
  logic [31:0]   psr_reg;
  logic [31:0]   ibr_reg;
  logic [31:0]   cea_reg;
  logic [31:0]   cfa_reg;
  logic          neutRev_reg;
  logic          neutOv_reg;
  logic          prevSuper_reg;
  logic          squash_reg;
  logic          ack_reg;
  logic          waitReq_reg;
  logic [31:0]   rdata_reg;
  logic [1:0]    resp_reg;
  sqsc_seq_t     seq_reg;
  logic          taken_reg;
  logic [31:0]   ila_reg;
  logic [31:0]   iea_reg;
  logic [31:0]   ifa_reg;
  logic [31:0]   adr_reg;

  logic          isSuper;
  logic          instrLive;
  logic          takenFlow;
  logic          privViol;
  logic          doPush;
  logic          doPop;
  logic [TOS_W-1:0] tos;
  logic [TOS_W-1:0] tosNext;
  logic          sovHit;
  logic          sunHit;
  logic [3:0]    extAct;
  logic          pending;
  logic [3:0]    vecClass;
  logic [31:0]   branchDest;
  logic [31:0]   vecAddr;
  logic          busReq;
  logic          busDone;
  logic          ssrWr;
  logic [31:0]   ssrSetMask;
  logic [31:0]   ssrIrqMask;

  // byte-lane merge, shared by every writable register
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] laneEn, input logic [31:0] wm);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (laneEn[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return (r & wm) | (old & ~wm);
  endfunction

  // decode of the executing instruction; a squashed shadow has no effects
  assign isSuper   = ssr_reg[SSR_SUPER];
  assign instrLive = instr.valid && !squash_reg;
  assign privViol  = instrLive && instr.priv && !isSuper;
  assign takenFlow = instrLive && !privViol && (instr.op == SQSC_OP_BRANCH ||
                     instr.op == SQSC_OP_CALL || instr.op == SQSC_OP_RET);
  assign doPush = instrLive && !privViol && (instr.op == SQSC_OP_CALL ||
                  instr.op == SQSC_OP_TRAPI || instr.op == SQSC_OP_PUSH ||
                  instr.op == SQSC_OP_OVNEUI);
  assign doPop  = instrLive && !privViol && (instr.op == SQSC_OP_RET || instr.op == SQSC_OP_POP);
  assign tos    = ssr_reg[SSR_TOS_LO +: TOS_W];
  // modulo 32 wrap by width
  assign tosNext = doPush ? tos + 5'h01 : (doPop ? tos - 5'h01 : tos);
  // near-full: the entry written is the third from the top; near-empty: popping entry 0
  assign sovHit = doPush && (tosNext == 5'h1d);
  assign sunHit = doPop && (tos == 5'h00);

  // relative branches use the executing address
  assign branchDest = instr.absolute ? instr.target : cea_reg + instr.target;

  // flag set sources; sets win over a same-cycle software clear
  assign extAct = ~extIrqN;
  always_comb begin
    ssrSetMask = 32'h00000000;
    ssrSetMask[SSR_MALFLG]  = malEvent;
    ssrSetMask[SSR_BRKFLG]  = brkEvent;
    ssrSetMask[SSR_TIMFLG]  = timEvent;
    ssrSetMask[SSR_SOVFLG]  = sovHit;
    ssrSetMask[SSR_SUNFLG]  = sunHit;
    ssrSetMask[SSR_TRPFLG]  = instrLive && !privViol && instr.op == SQSC_OP_TRAPI;
    ssrSetMask[SSR_PRVFLG]  = privViol;
    ssrSetMask[SSR_EXT1FLG] = extAct[0];
    ssrSetMask[SSR_EXT2FLG] = extAct[1];
    ssrSetMask[SSR_EXT3FLG] = extAct[2];
    ssrSetMask[SSR_EXT4FLG] = extAct[3];
  end

  // enabled pending flags, gated by master enable
  always_comb begin
    ssrIrqMask = 32'h00000000;
    ssrIrqMask[SSR_MALFLG]  = ssr_reg[SSR_MALFLG+1];
    ssrIrqMask[SSR_BRKFLG]  = ssr_reg[SSR_BRKFLG+1] | ssr_reg[SSR_BRKFLG+2];
    ssrIrqMask[SSR_TIMFLG]  = ssr_reg[SSR_TIMFLG+1];
    ssrIrqMask[SSR_SOVFLG]  = ssr_reg[SSR_SOVEN];
    ssrIrqMask[SSR_SUNFLG]  = ssr_reg[SSR_SUNEN];
    ssrIrqMask[SSR_TRPFLG]  = ssr_reg[SSR_TRPEN];
    ssrIrqMask[SSR_PRVFLG]  = ssr_reg[SSR_PRVEN];
    ssrIrqMask[SSR_EXT1FLG] = ssr_reg[SSR_EXT1EN];
    ssrIrqMask[SSR_EXT2FLG] = ssr_reg[SSR_EXT23EN];
    ssrIrqMask[SSR_EXT3FLG] = ssr_reg[SSR_EXT23EN];
    ssrIrqMask[SSR_EXT4FLG] = ssr_reg[SSR_EXT4EN];
  end
  // no sequence at all while master enable is clear
  assign pending = ssr_reg[SSR_MEN] && |(ssr_reg & ssrIrqMask);

  // four class bits pick one of sixteen vectors
  assign vecClass = {|(ssr_reg & ssrIrqMask & ~32'h01c28000),
                     (ssr_reg[SSR_TRPFLG] & ssrIrqMask[SSR_TRPFLG]) |
                     (ssr_reg[SSR_PRVFLG] & ssrIrqMask[SSR_PRVFLG]),
                     |(ssr_reg & ssrIrqMask & 32'h00c00000),
                     ssr_reg[SSR_EXT1FLG] & ssrIrqMask[SSR_EXT1FLG]};
  assign vecAddr = ibr_reg + {26'h0000000, 2'b00, vecClass} * VEC_SLOT_BYTES;

  // bus decode: one-cycle wait, answered on the second edge
  assign busReq  = (avs_read || avs_write) && !ack_reg;
  // writes land on the edge that completes the transfer, never while waitrequest is high,
  // so a master that changed its data during the wait could not leave a stale word behind
  assign busDone = (avs_read || avs_write) && ack_reg;
  assign ssrWr   = busDone && avs_write && avs_address == OFF_SSR && busSuper;

  // sequencer state: shadow slot handling
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg   <= SQSC_RUN;
      squash_reg  <= 1'b0;
      neutOv_reg  <= 1'b0;
      neutRev_reg <= 1'b0;
    end else begin
      case (state_reg)
        SQSC_RUN: begin
          if (pending) begin
            state_reg  <= SQSC_SHADOW;
            squash_reg <= 1'b1;
          end else if (takenFlow) begin
            state_reg  <= SQSC_SHADOW;
            // reverse mode squashes only where override was asked
            squash_reg <= neutRev_reg ? neutOv_reg : !neutOv_reg;
          end
        end
        SQSC_SHADOW: begin
          state_reg  <= SQSC_RUN;
          squash_reg <= 1'b0;
        end
        default: begin
          state_reg  <= SQSC_RUN;
          squash_reg <= 1'b0;
        end
      endcase
      // neutralization controls also act from an executed shadow slot
      if (instrLive && (instr.op == SQSC_OP_OVNEUT || instr.op == SQSC_OP_OVNEUI)) begin
        neutOv_reg <= 1'b1;
      end else if (takenFlow && state_reg == SQSC_RUN) begin
        neutOv_reg <= 1'b0;
      end
      if (instrLive && instr.op == SQSC_OP_REVNEU) begin
        neutRev_reg <= !neutRev_reg;
      end
    end
  end

  // program counters and interrupt save registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cea_reg  <= RESET_ADDR;
      cfa_reg  <= RESET_ADDR + VEC_SLOT_BYTES;
      iea_reg  <= 32'h00000000;
      ifa_reg  <= 32'h00000000;
      ila_reg  <= 32'h00000000;
      taken_reg <= 1'b0;
    end else begin
      taken_reg <= 1'b0;
      cea_reg <= cfa_reg;
      if (instrLive && !privViol) begin
        ila_reg <= cea_reg;
      end
      if (state_reg == SQSC_RUN && pending) begin
        iea_reg  <= cea_reg;
        ifa_reg  <= cfa_reg;
        cfa_reg  <= vecAddr;
        taken_reg <= 1'b1;
      end else if (state_reg == SQSC_RUN && takenFlow) begin
        cfa_reg <= (instr.op == SQSC_OP_RET) ? stackTop : branchDest;
      end else if (state_reg == SQSC_RUN && instrLive && instr.op == SQSC_OP_RTI) begin
        cfa_reg <= ifa_reg;
      end else begin
        cfa_reg <= cfa_reg + VEC_SLOT_BYTES;
      end
    end
  end

  // address holding register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      adr_reg <= 32'h00000000;
    end else if (instrLive && instr.addrGen) begin
      adr_reg <= instr.addrValue;
    end
  end

  // sequencer status register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ssr_reg       <= SSR_RESET;
      prevSuper_reg <= 1'b1;
    end else begin
      logic [31:0] s;
      s = ssrWr ? laneMerge(ssr_reg, avs_writedata, avs_byteenable, SSR_WMASK) : ssr_reg;
      s = s | ssrSetMask;
      s[SSR_TOS_LO +: TOS_W] = tosNext;
      s[SSR_BRANCH] = takenFlow;
      if (state_reg == SQSC_RUN && pending) begin
        prevSuper_reg <= ssr_reg[SSR_SUPER];
        s[SSR_SUPER] = 1'b1;
        // master enable drops on entry so a still-set flag cannot re-enter and
        // overwrite the saved counters and mode before the handler runs
        s[SSR_MEN] = 1'b0;
      end else if (instrLive && instr.op == SQSC_OP_RTI && isSuper) begin
        s[SSR_SUPER] = prevSuper_reg;
      end
      ssr_reg <= s;
    end
  end

  // processor status and interrupt base registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      psr_reg <= 32'h00000000;
      ibr_reg <= 32'h00000000;
    end else if (busDone && avs_write) begin
      if (avs_address == OFF_PSR) begin
        // reserved bits forced to zero
        psr_reg <= laneMerge(psr_reg, avs_writedata, avs_byteenable, PSR_WMASK);
      end
      if (avs_address == OFF_IBR && busSuper) begin
        ibr_reg <= laneMerge(ibr_reg, avs_writedata, avs_byteenable, 32'hfffffffc);
      end
    end
  end

  // avalon read path and response
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_reg     <= 1'b0;
      waitReq_reg <= 1'b1;
      rdata_reg   <= 32'h00000000;
      resp_reg    <= 2'b00;
    end else begin
      ack_reg     <= busReq;
      // own flop keeps the bus output glitch free; low for one cycle per request
      waitReq_reg <= !busReq;
      if (busReq) begin
        resp_reg  <= 2'b00;
        rdata_reg <= 32'h00000000;
        case (avs_address)
          OFF_SSR: begin
            if (busSuper) begin
              rdata_reg <= ssr_reg;
            end else begin
              resp_reg <= 2'b10;
            end
          end
          OFF_PSR: rdata_reg <= psr_reg;
          OFF_IBR: rdata_reg <= ibr_reg;
          OFF_CTL: rdata_reg <= {30'h00000000, neutRev_reg, psr_reg[PSR_BANK]};
          default: resp_reg <= 2'b11;
        endcase
      end
    end
  end

  // registered outputs to the datapath
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_reg <= '0;
    end else begin
      seq_reg.fetchAddr <= cfa_reg;
      seq_reg.pushEn    <= doPush;
      seq_reg.popEn     <= doPop;
      // trap pushes its immediate, calls push the next address
      seq_reg.pushData  <= (instr.op == SQSC_OP_TRAPI) ?
                           {21'h000000, instr.trapImm} : cfa_reg;
      seq_reg.stackPtr  <= tosNext;
    end
  end

  assign avs_waitrequest = waitReq_reg;
  assign avs_readdata    = rdata_reg;
  assign avs_response    = resp_reg;
  assign seqOut          = seq_reg;
  assign squashShadow    = squash_reg;
  assign bankSel         = psr_reg[PSR_BANK];
  assign execAddr        = cea_reg;
  assign lastAddr        = ila_reg;
  assign irqExecSave     = iea_reg;
  assign irqFetchSave    = ifa_reg;
  assign addrHold        = adr_reg;
  assign irqTaken        = taken_reg;
  assign ssrOut          = ssr_reg;

endmodule

// ### include/sqsc_pkg.sv
// sqsc_pkg: constants, field layouts and types for the sequencer supervisor control block
// assumes one 25 MHz clock and an avalon-mm register bus with 32-bit data
package sqsc_pkg;

  localparam int ADDR_W = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SSR = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PSR = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_IBR = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CTL = 4'hc;

  // sequencer status bit positions
  localparam int SSR_MALFLG  = 0;
  localparam int SSR_SUPER   = 2;
  localparam int SSR_BRANCH  = 4;
  localparam int SSR_BRKFLG  = 6;
  localparam int SSR_TIMFLG  = 9;
  localparam int SSR_SOVFLG  = 11;
  localparam int SSR_SOVEN   = 12;
  localparam int SSR_SUNFLG  = 13;
  localparam int SSR_SUNEN   = 14;
  localparam int SSR_TRPFLG  = 15;
  localparam int SSR_TRPEN   = 16;
  localparam int SSR_PRVFLG  = 17;
  localparam int SSR_PRVEN   = 18;
  localparam int SSR_EXT4FLG = 19;
  localparam int SSR_EXT4EN  = 20;
  localparam int SSR_EXT23EN = 21;
  localparam int SSR_EXT2FLG = 22;
  localparam int SSR_EXT3FLG = 23;
  localparam int SSR_EXT1FLG = 24;
  localparam int SSR_EXT1EN  = 25;
  localparam int SSR_MEN     = 26;
  localparam int SSR_TOS_LO  = 27;
  localparam int TOS_W       = 5;

  localparam logic [31:0] SSR_RESET = 32'hf8000004;
  // bits that never hold state: the superivsor copy at 3 and branch copy 5 are zero here
  localparam logic [31:0] SSR_WMASK = 32'hffffffd7;

  // processor status layout
  localparam int PSR_CARRY = 0;
  localparam int PSR_BANK  = 1;
  localparam int PSR_FLR_LO = 8;
  localparam int PSR_SAR_LO = 16;
  localparam int PSR_FIELD_W = 5;
  localparam logic [31:0] PSR_WMASK = 32'h001f1f03;

  localparam logic [31:0] VEC_SLOT_BYTES = 32'h00000004;
  localparam int          TRAP_IMM_W = 11;

  // control operations presented by the decoder with the executing instruction
  typedef enum logic [3:0] {
    SQSC_OP_NONE   = 4'h0,
    SQSC_OP_BRANCH = 4'h1,  // taken branch
    SQSC_OP_CALL   = 4'h2,  // push return address and branch
    SQSC_OP_RET    = 4'h3,  // branch to top of stack and pop
    SQSC_OP_OVNEUT = 4'h4,
    SQSC_OP_OVNEUI = 4'h5,
    SQSC_OP_REVNEU = 4'h6,
    SQSC_OP_TRAPI  = 4'h7,
    SQSC_OP_RTI    = 4'h8,  // return from trap handler
    SQSC_OP_PUSH   = 4'h9,
    SQSC_OP_POP    = 4'ha
  } sqsc_op_t;

  typedef struct packed {
    logic          valid;
    sqsc_op_t      op;
    logic          priv;       // instruction reserved for supervisor mode
    logic          addrGen;    // address generation instruction
    logic [31:0]   addrValue;
    logic [31:0]   target;     // displacement or absolute target
    logic          absolute;
    logic [TRAP_IMM_W-1:0] trapImm;
  } sqsc_instr_t;

  typedef struct packed {
    logic [31:0] fetchAddr;
    logic        pushEn;
    logic        popEn;
    logic [31:0] pushData;
    logic [TOS_W-1:0] stackPtr;
  } sqsc_seq_t;

  typedef enum logic [1:0] {
    SQSC_RUN    = 2'b01,
    SQSC_SHADOW = 2'b10
  } sqsc_state_t;

endpackage

// ### verification/sqsc_code_side.sv
// sqsc_code_side: call stack storage and external request lines beside the sequencer
// assumes pushes arrive with the pointer value after the push
`timescale 1ns/1ps

module sqsc_code_side
  import sqsc_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire sqsc_seq_t seqOut,
  input  wire logic [3:0] irqReq,
  output logic [31:0]    stackTop,
  output logic [3:0]     extIrqN
);
  logic [31:0] stackMem [32];

  // the slot written by a push sits under the pointer reported with it
  always_ff @(posedge sys_clk) begin
    if (seqOut.pushEn) begin
      stackMem[seqOut.stackPtr] <= seqOut.pushData;
    end
  end
  assign stackTop = stackMem[seqOut.stackPtr];

  // lines are active low, so a raised request pulls its line down
  assign extIrqN = ~irqReq;
endmodule

// ### verification/sqsc_sequencer_assertions.sv
// sqsc_sequencer_assertions: temporal checks on the sequencer ports
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps

module sqsc_sequencer_assertions
  import sqsc_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_waitrequest,
  input wire logic [31:0]       avs_readdata,
  input wire logic [1:0]        avs_response,
  input wire logic              busSuper,
  input wire sqsc_instr_t       instr,
  input wire logic              squashShadow,
  input wire sqsc_seq_t         seqOut,
  input wire logic [31:0]       execAddr,
  input wire logic              irqTaken,
  input wire logic [31:0]       ssrOut
);
  logic take;
  logic free;
  assign take = instr.valid && !squashShadow;

  // default policy only holds until an override or reverse op is seen
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      free <= 1'b1;
    end else if (take && instr.op inside {SQSC_OP_OVNEUT, SQSC_OP_OVNEUI, SQSC_OP_REVNEU}) begin
      free <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_shadow_squash: assert property (
    free && take && instr.op == SQSC_OP_BRANCH |=> squashShadow)
    else $error("shadow slot not neutralized");
  chk_shadow_once: assert property (
    squashShadow |=> !squashShadow)
    else $error("neutralized slot lasted beyond one cycle");
  chk_rel_target: assert property (
    take && instr.op == SQSC_OP_BRANCH && !instr.absolute
    |=> ##1 seqOut.fetchAddr == $past(execAddr, 2) + $past(instr.target, 2))
    else $error("branch target not relative to executing address");
  chk_push_up: assert property (
    take && instr.op == SQSC_OP_PUSH |=> ssrOut[31:27] == $past(ssrOut[31:27]) + 5'h01)
    else $error("push did not raise pointer");
  chk_pop_down: assert property (
    take && instr.op == SQSC_OP_POP |=> ssrOut[31:27] == $past(ssrOut[31:27]) - 5'h01)
    else $error("pop did not lower pointer");
  chk_near_full: assert property (
    take && instr.op == SQSC_OP_PUSH && ssrOut[31:27] == 5'h1c |=> ssrOut[SSR_SOVFLG])
    else $error("overflow flag missing");
  chk_near_empty: assert property (
    take && instr.op == SQSC_OP_POP && ssrOut[31:27] == 5'h00 |=> ssrOut[SSR_SUNFLG])
    else $error("underflow flag missing");
  chk_priv_user: assert property (
    take && instr.priv && !ssrOut[SSR_SUPER] |=> ssrOut[SSR_PRVFLG])
    else $error("privilege violation not flagged");
  chk_men_block: assert property (
    !ssrOut[SSR_MEN] && $past(!ssrOut[SSR_MEN]) |-> !irqTaken)
    else $error("interrupt taken with master enable clear");
  chk_irq_super: assert property (
    $rose(irqTaken) |-> ##[0:1] ssrOut[SSR_SUPER])
    else $error("interrupt did not enter supervisor mode");
  chk_user_refused: assert property (
    avs_read && avs_waitrequest && avs_address == OFF_SSR && !busSuper
    |=> !avs_waitrequest && avs_response == 2'b10 && avs_readdata == 32'h00000000)
    else $error("user read of sequencer status not refused");
endmodule

bind sqsc_sequencer sqsc_sequencer_assertions sqsc_sequencer_assertions_inst (.*);

// ### verification/tb_top.sv
// tb_top: directed scenarios for the sequencer supervisor control block
// assumes a 25 MHz clock and an avalon-mm master that waits for waitrequest low
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_top
  import sqsc_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [1:0]        avs_response;
  logic              busSuper = 1'b1;
  sqsc_instr_t       instr = '0;
  logic [31:0]       stackTop;
  logic [3:0]        extIrqN;
  logic [3:0]        irqReq = 4'h0;
  logic              malEvent = 1'b0;
  logic              timEvent = 1'b0;
  logic              brkEvent = 1'b0;
  sqsc_seq_t         seqOut;
  logic              squashShadow;
  logic              bankSel;
  logic [31:0]       execAddr;
  logic [31:0]       lastAddr;
  logic [31:0]       irqExecSave;
  logic [31:0]       irqFetchSave;
  logic [31:0]       addrHold;
  logic              irqTaken;
  logic [31:0]       ssrOut;
  logic [31:0]       rd;
  logic [1:0]        rsp;
  logic              irqSeen = 1'b0;
  logic [31:0]       irqFetch;
  int                n_fail = 0;
  int                comparisons = 0;

  sqsc_sequencer sqsc_sequencer_inst (.*);
  sqsc_code_side sqsc_code_side_inst (.*);

  always #20 sys_clk = ~sys_clk;

  logic              irqTakenD = 1'b0;
  // pulses are short, so keep a sticky copy; the vector reaches fetchAddr an edge later
  always @(posedge sys_clk) begin
    irqTakenD <= irqTaken;
    if (irqTakenD === 1'b1) begin
      irqSeen <= 1'b1;
      irqFetch <= seqOut.fetchAddr;
    end
  end

  task automatic complete_run;
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic reset_dut;
    @(posedge sys_clk);
    rst <= 1'b1;
    instr <= '0;
    irqReq <= 4'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic s);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= d;
    busSuper <= s;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // present one instruction; f = {absolute, addrGen, priv}; held until the next call
  task automatic ex(input sqsc_op_t o, input logic [31:0] t, input logic [2:0] f);
    @(posedge sys_clk);
    instr.valid <= 1'b1;
    instr.op <= o;
    instr.target <= t;
    instr.addrValue <= t;
    instr.trapImm <= t[TRAP_IMM_W-1:0];
    instr.priv <= f[0];
    instr.addrGen <= f[1];
    instr.absolute <= f[2];
    @(negedge sys_clk);
  endtask

  task automatic wait_irq;
    for (int i = 0; i < 10 && irqSeen !== 1'b1; i++) @(negedge sys_clk);
  endtask

  task automatic t_regs;
    reset_dut();
    bus(1'b0, OFF_SSR, 32'h0, 1'b1);
    `CHK("ssr reset", SSR_RESET, rd)
    `CHK("ssr port", 32'hf8000004, ssrOut)
    bus(1'b1, OFF_PSR, 32'h001f1f03, 1'b1); // reserved bits left zero
    bus(1'b0, OFF_PSR, 32'h0, 1'b1);
    `CHK("psr fields", 32'h001f1f03, rd)
    `CHK("bank select", 1'b1, bankSel)
    bus(1'b0, 4'h2, 32'h0, 1'b1);
    `CHK("unmapped", 2'b11, rsp)
    bus(1'b1, OFF_SSR, 32'h0, 1'b0);
    `CHK("user write", 2'b10, rsp)
    bus(1'b0, OFF_SSR, 32'h0, 1'b0);
    `CHK("user read", 32'h0, rd)
    bus(1'b0, OFF_SSR, 32'h0, 1'b1);
    `CHK("ssr kept", SSR_RESET, rd)
  endtask

  task automatic t_branch;
    reset_dut();
    ex(SQSC_OP_NONE, 32'h00abcde0, 3'b010);
    ex(SQSC_OP_BRANCH, 32'h00000100, 3'b100);
    `CHK("addr hold", 32'h00abcde0, addrHold)
    `CHK("last addr", 32'h00000004, lastAddr)
    ex(SQSC_OP_PUSH, 32'h0, 3'b000);
    `CHK("shadow squashed", 1'b1, squashShadow)
    ex(SQSC_OP_NONE, 32'h0, 3'b000);
    `CHK("fetch target", 32'h00000100, seqOut.fetchAddr)
    `CHK("exec target", 32'h00000100, execAddr)
    `CHK("target slot", 1'b0, squashShadow)
    `CHK("shadow push dropped", 5'h1f, ssrOut[31:27])
  endtask

  task automatic t_override;
    reset_dut();
    ex(SQSC_OP_OVNEUT, 32'h0, 3'b000);
    ex(SQSC_OP_BRANCH, 32'h00000040, 3'b000);
    ex(SQSC_OP_PUSH, 32'h0, 3'b000);
    `CHK("override runs", 1'b0, squashShadow)
    ex(SQSC_OP_OVNEUI, 32'h0, 3'b000);
    `CHK("shadow push kept", 5'h00, ssrOut[31:27])
    ex(SQSC_OP_BRANCH, 32'h00000040, 3'b000);
    `CHK("override increment", 5'h01, ssrOut[31:27])
    ex(SQSC_OP_REVNEU, 32'h0, 3'b000);
    `CHK("second override", 1'b0, squashShadow)
    ex(SQSC_OP_BRANCH, 32'h00000040, 3'b000);
    ex(SQSC_OP_NONE, 32'h0, 3'b000);
    `CHK("reverse runs", 1'b0, squashShadow)
  endtask

  task automatic t_stack;
    reset_dut();
    repeat (29) ex(SQSC_OP_PUSH, 32'h0, 3'b000);
    ex(SQSC_OP_NONE, 32'h0, 3'b000);
    `CHK("no early overflow", 1'b0, ssrOut[SSR_SOVFLG])
    ex(SQSC_OP_PUSH, 32'h0, 3'b000);
    ex(SQSC_OP_NONE, 32'h0, 3'b000);
    `CHK("pointer 29", 5'h1d, ssrOut[31:27])
    `CHK("overflow", 1'b1, ssrOut[SSR_SOVFLG])
    repeat (29) ex(SQSC_OP_POP, 32'h0, 3'b000);
    ex(SQSC_OP_NONE, 32'h0, 3'b000);
    `CHK("no early underflow", 1'b0, ssrOut[SSR_SUNFLG])
    ex(SQSC_OP_POP, 32'h0, 3'b000);
    ex(SQSC_OP_NONE, 32'h0, 3'b000);
    `CHK("underflow", 1'b1, ssrOut[SSR_SUNFLG])
    `CHK("pointer wraps", 5'h1f, ssrOut[31:27])
    `CHK("pop strobe", 1'b1, seqOut.popEn)
    `CHK("pop pointer", 5'h1f, seqOut.stackPtr)
  endtask

  task automatic t_trap;
    reset_dut();
    bus(1'b1, OFF_IBR, 32'h00001000, 1'b1);
    bus(1'b1, OFF_SSR, 32'hfc010000, 1'b1); // user mode, master and trap enable
    irqSeen = 1'b0;
    ex(SQSC_OP_TRAPI, 32'h000005a5, 3'b000);
    ex(SQSC_OP_NONE, 32'h0, 3'b000);
    `CHK("trap push", 1'b1, seqOut.pushEn)
    `CHK("trap value", 32'h000005a5, seqOut.pushData)
    `CHK("trap flag", 1'b1, ssrOut[SSR_TRPFLG])
    wait_irq();
    `CHK("trap taken", 1'b1, irqSeen)
    `CHK("trap super", 1'b1, ssrOut[SSR_SUPER])
    `CHK("trap vector", 32'h00001010, irqFetch)
    `CHK("trap stacked", 32'h000005a5, stackTop)
    bus(1'b0, OFF_SSR, 32'h0, 1'b1);
    bus(1'b1, OFF_SSR, rd & 32'hfbff7fff, 1'b1); // flag and master cleared by handler
    ex(SQSC_OP_RTI, 32'h0, 3'b000);
    ex(SQSC_OP_NONE, 32'h0, 3'b000);
    `CHK("mode restored", 1'b0, ssrOut[SSR_SUPER])
  endtask

  task automatic t_irq;
    reset_dut();
    bus(1'b1, OFF_SSR, 32'hf8000000, 1'b1); // user mode, master off
    irqSeen = 1'b0;
    ex(SQSC_OP_NONE, 32'h0, 3'b001);
    ex(SQSC_OP_NONE, 32'h0, 3'b000);
    `CHK("priv flag", 1'b1, ssrOut[SSR_PRVFLG])
    @(posedge sys_clk);
    irqReq <= 4'h1;
    malEvent <= 1'b1;
    timEvent <= 1'b1;
    brkEvent <= 1'b1;
    @(posedge sys_clk);
    malEvent <= 1'b0;
    timEvent <= 1'b0;
    brkEvent <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("line flag", 1'b1, ssrOut[SSR_EXT1FLG])
    `CHK("event flag", 1'b1, ssrOut[SSR_MALFLG])
    `CHK("timer flag", 1'b1, ssrOut[SSR_TIMFLG])
    `CHK("break flag", 1'b1, ssrOut[SSR_BRKFLG])
    `CHK("no routine", 1'b0, irqSeen)
    bus(1'b1, OFF_SSR, 32'hfe000000, 1'b1); // master and line-one enable
    wait_irq();
    `CHK("line taken", 1'b1, irqSeen)
    `CHK("line super", 1'b1, ssrOut[SSR_SUPER])
    `CHK("line vector", 32'h00000004, irqFetch)
    `CHK("exec save", 32'h00000030, irqExecSave)
    `CHK("fetch save", 32'h00000034, irqFetchSave)
  endtask

  initial begin
    t_regs();
    t_branch();
    t_override();
    t_stack();
    t_trap();
    t_irq();
    complete_run();
  end

  // the scenarios need about 260 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
endmodule
